// ===== mem_map_defs.vh
// Address map, region codes and attribute encodings for the default memory map
`ifndef MEM_MAP_DEFS_VH
`define MEM_MAP_DEFS_VH

// Region base addresses
`define MAP_SRAM_BASE 32'h20000000
`define MAP_PERIPH_BASE 32'h40000000
`define MAP_EXTRAM_BASE 32'h60000000
`define MAP_EXTDEV_BASE 32'ha0000000
`define MAP_EXTDEV_NS_BASE 32'hc0000000
`define MAP_CORE_PERIPH_BASE 32'he0000000
`define MAP_VENDOR_BASE 32'he0100000

// Memory type codes
`define MTYPE_NORMAL 2'h0
`define MTYPE_DEVICE 2'h1
`define MTYPE_STRONG 2'h2

// Region codes
`define REGION_CODE 3'h0
`define REGION_SRAM 3'h1
`define REGION_PERIPH 3'h2
`define REGION_EXTRAM 3'h3
`define REGION_EXTDEV 3'h4
`define REGION_CORE_PERIPH 3'h5
`define REGION_VENDOR 3'h6

// Access size codes
`define SIZE_BYTE 2'h0
`define SIZE_HALF 2'h1
`define SIZE_WORD 2'h2

// Barrier kind codes
`define BARRIER_DATA_MEM 2'h1
`define BARRIER_DATA_SYNC 2'h2
`define BARRIER_INSTR_SYNC 2'h3

`endif

// ===== region_decoder.v
// Combinational decode of an address into region and attributes
`include "mem_map_defs.vh"
module region_decoder (
  // Address
  input wire [31:0] i_addr,
  // Attributes
  output reg [2:0] o_region,
  output reg [1:0] o_mem_type,
  output reg o_shareable,
  output reg o_no_execute_attribute
);

  always @* begin
    o_region = `REGION_CODE;
    o_mem_type = `MTYPE_NORMAL;
    o_shareable = 1'b0;
    o_no_execute_attribute = 1'b0;
    if (i_addr < `MAP_SRAM_BASE) begin
      o_region = `REGION_CODE;
    end else if (i_addr < `MAP_PERIPH_BASE) begin
      o_region = `REGION_SRAM;
    end else if (i_addr < `MAP_EXTRAM_BASE) begin
      o_region = `REGION_PERIPH;
      o_mem_type = `MTYPE_DEVICE;
      o_no_execute_attribute = 1'b1;
    end else if (i_addr < `MAP_EXTDEV_BASE) begin
      o_region = `REGION_EXTRAM;
    end else if (i_addr < `MAP_CORE_PERIPH_BASE) begin
      o_region = `REGION_EXTDEV;
      o_mem_type = `MTYPE_DEVICE;
      o_shareable = (i_addr < `MAP_EXTDEV_NS_BASE);
      o_no_execute_attribute = 1'b1;
    end else if (i_addr < `MAP_VENDOR_BASE) begin
      o_region = `REGION_CORE_PERIPH;
      o_mem_type = `MTYPE_STRONG;
      o_shareable = 1'b1;
      o_no_execute_attribute = 1'b1;
    end else begin
      o_region = `REGION_VENDOR;
      o_mem_type = `MTYPE_DEVICE;
      o_no_execute_attribute = 1'b1;
    end
  end

endmodule

// ===== lane_steer.v
// Byte lane steering for data in either byte order
`include "mem_map_defs.vh"
module lane_steer (
  // Access
  input wire [1:0] i_size,
  input wire [1:0] i_offset,
  input wire i_big,
  input wire [31:0] i_data,
  // Steered result
  output wire [31:0] o_data,
  output wire [3:0] o_strobe
);

  function [31:0] swap_bytes;
    input [31:0] d;
    begin
      swap_bytes = {d[7:0], d[15:8], d[23:16], d[31:24]};
    end
  endfunction

  wire [3:0] base_strobe = (i_size == `SIZE_WORD) ? 4'hf :
    (i_size == `SIZE_HALF) ? (i_offset[1] ? 4'hc : 4'h3) : (4'h1 << i_offset);
  wire [31:0] le_data = (i_size == `SIZE_WORD) ? i_data :
    (i_size == `SIZE_HALF) ? (i_offset[1] ? {i_data[15:0], 16'h0000} : {16'h0000, i_data[15:0]}) :
    ({24'h000000, i_data[7:0]} << {i_offset, 3'b000});
  wire [31:0] be_src = (i_size == `SIZE_WORD) ? swap_bytes(i_data) :
    (i_size == `SIZE_HALF) ? {16'h0000, i_data[7:0], i_data[15:8]} : i_data;
  wire [31:0] be_data = (i_size == `SIZE_WORD) ? be_src :
    (i_size == `SIZE_HALF) ? (i_offset[1] ? {be_src[15:0], 16'h0000} : {16'h0000, be_src[15:0]}) :
    ({24'h000000, be_src[7:0]} << {i_offset, 3'b000});

  assign o_data = i_big ? be_data : le_data;
  assign o_strobe = base_strobe;

endmodule

// ===== mem_attr_unit.v
// Default memory map attribute, ordering and barrier unit between core and system bus
// How it works
// - Addresses up to 0x1fffffff are Normal, fetch and data allowed.
// - SRAM 0x20000000-0x3fffffff is Normal, fetch and data allowed.
// - External RAM 0x60000000-0x9fffffff is Normal and executable.
// - Peripheral and external device regions are Device, no-execute, fetch blocked.
// - Fetch from a no-execute region raises hard fault.
// - Core peripheral space is Strongly-ordered, no-execute, word accesses only.
// - Normal accesses may be reordered; no ordering wait imposed.
// - Device accesses wait for outstanding Device or Strongly-ordered ones.
// - Strongly-ordered accesses wait for every outstanding access.
// - Device writes may be buffered; Strongly-ordered writes never are.
// - Strongly-ordered memory is always reported shareable.
// - Shareability is signalled to the fabric, which keeps coherency.
// - Device and Strongly-ordered pairs are observed in program order.
// - Byte, halfword and word transfers supported.
// - Data accesses use configured little or big endian order.
// - Fetches and core peripheral accesses always little endian.
// - Little endian places least significant byte at lowest address.
// - Data memory barrier drains outstanding transactions before new ones.
// - Data sync barrier drains outstanding transactions before next instruction.
// - Instruction sync barrier flushes the fetch path to refetch.
// - Fixed non-remappable 32-bit, 4GB address map.
`include "mem_map_defs.vh"
module mem_attr_unit #(
  parameter OUTSTANDING_W = 4,
  parameter BIG_ENDIAN = 0
) (
  // Clock and reset
  input wire i_clk,
  input wire i_sys_rst,
  // Core data request
  input wire i_req_valid,
  input wire i_req_fetch,
  input wire i_req_write,
  input wire [1:0] i_req_size,
  input wire [31:0] i_req_addr,
  input wire [31:0] i_req_wdata,
  output wire o_req_ready,
  // Core barrier request
  input wire i_barrier_valid,
  input wire [1:0] i_barrier_kind,
  output wire o_barrier_done,
  // Core status
  output reg o_hard_fault,
  output reg o_size_fault,
  output reg o_flush_fetch,
  output wire o_stall_execute,
  // Bus request
  output reg o_bus_valid,
  output reg o_bus_fetch,
  output reg o_bus_write,
  output reg [31:0] o_bus_addr,
  output reg [31:0] o_bus_wdata,
  output reg [3:0] o_bus_strobe,
  output reg [1:0] o_bus_mem_type,
  output reg o_bus_shareable,
  output reg o_bus_bufferable,
  input wire i_bus_ready,
  // Bus completion
  input wire i_bus_done
);

  localparam ST_IDLE = 3'b001;
  localparam ST_DRAIN = 3'b010;
  localparam ST_FLUSH = 3'b100;

  wire [2:0] region;
  wire [1:0] mem_type;
  wire shareable;
  wire no_execute_attribute;
  wire [31:0] steered;
  wire [3:0] strobe;

  reg [2:0] state;
  reg [2:0] next_state;
  reg [OUTSTANDING_W-1:0] outstanding;
  reg [OUTSTANDING_W-1:0] strong_out;
  reg [OUTSTANDING_W-1:0] next_outstanding;
  reg [OUTSTANDING_W-1:0] next_strong_out;
  reg [1:0] pending_kind;
  reg barrier_pulse;

  // Strong_out counts outstanding Device and Strongly-ordered accesses
  region_decoder u_decode (
    .i_addr(i_req_addr),
    .o_region(region),
    .o_mem_type(mem_type),
    .o_shareable(shareable),
    .o_no_execute_attribute(no_execute_attribute)
  );

  // Forced little endian for fetch and core peripherals
  wire use_big = (BIG_ENDIAN != 0) && !i_req_fetch && (region != `REGION_CORE_PERIPH);

  lane_steer u_lanes (
    .i_size(i_req_size),
    .i_offset(i_req_addr[1:0]),
    .i_big(use_big),
    .i_data(i_req_wdata),
    .o_data(steered),
    .o_strobe(strobe)
  );

  function [OUTSTANDING_W-1:0] bump;
    input [OUTSTANDING_W-1:0] v;
    input up;
    input down;
    begin
      bump = v + {{(OUTSTANDING_W-1){1'b0}}, up} - {{(OUTSTANDING_W-1){1'b0}}, down};
    end
  endfunction

  wire fetch_fault = i_req_fetch && no_execute_attribute;
  // Only word accesses in core peripheral space
  wire size_bad = (region == `REGION_CORE_PERIPH) && (i_req_size != `SIZE_WORD);
  wire size_reserved = (i_req_size == 2'h3);
  wire misaligned = ((i_req_size == `SIZE_WORD) && (i_req_addr[1:0] != 2'h0)) ||
    ((i_req_size == `SIZE_HALF) && i_req_addr[0]);
  wire rejected = fetch_fault || size_bad || size_reserved || misaligned;

  wire counters_full = &outstanding;
  wire wait_strong = (mem_type == `MTYPE_STRONG) && (outstanding != 0);
  // Device waits for outstanding Device and Strongly-ordered
  wire wait_device = (mem_type == `MTYPE_DEVICE) && (strong_out != 0);
  // Normal accesses never wait on ordering
  wire order_wait = wait_strong || wait_device;

  wire bus_free = !o_bus_valid || i_bus_ready;
  wire can_issue = (state == ST_IDLE) && !i_barrier_valid && !order_wait && !counters_full && bus_free;
  wire accept = i_req_valid && can_issue;
  wire issue = accept && !rejected;
  wire bus_taken = o_bus_valid && i_bus_ready;

  assign o_req_ready = can_issue;
  assign o_barrier_done = barrier_pulse;
  // Execution stalls while a data sync barrier drains
  assign o_stall_execute = (state == ST_DRAIN) && (pending_kind == `BARRIER_DATA_SYNC);

  always @* begin
    next_outstanding = bump(outstanding, issue, i_bus_done && (outstanding != 0));
    next_strong_out = bump(strong_out, issue && (mem_type != `MTYPE_NORMAL),
      i_bus_done && (strong_out != 0) && (outstanding == strong_out));
  end

  // Barrier sequencing
  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (i_barrier_valid) begin
          next_state = ST_DRAIN;
        end
      end
      ST_DRAIN: begin
        if (outstanding == 0 && !o_bus_valid) begin
          next_state = (pending_kind == `BARRIER_INSTR_SYNC) ? ST_FLUSH : ST_IDLE;
        end
      end
      ST_FLUSH: begin
        next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      state <= ST_IDLE;
      pending_kind <= 2'h0;
      barrier_pulse <= 1'b0;
      outstanding <= {OUTSTANDING_W{1'b0}};
      strong_out <= {OUTSTANDING_W{1'b0}};
      o_hard_fault <= 1'b0;
      o_size_fault <= 1'b0;
      o_flush_fetch <= 1'b0;
      o_bus_valid <= 1'b0;
      o_bus_fetch <= 1'b0;
      o_bus_write <= 1'b0;
      o_bus_addr <= 32'h00000000;
      o_bus_wdata <= 32'h00000000;
      o_bus_strobe <= 4'h0;
      o_bus_mem_type <= `MTYPE_NORMAL;
      o_bus_shareable <= 1'b0;
      o_bus_bufferable <= 1'b0;
    end else begin
      state <= next_state;
      outstanding <= next_outstanding;
      strong_out <= next_strong_out;
      if (state == ST_IDLE && i_barrier_valid) begin
        pending_kind <= i_barrier_kind;
      end
      barrier_pulse <= (state == ST_DRAIN && next_state == ST_IDLE) || (state == ST_FLUSH);
      // Flush fetch path after instruction sync barrier
      o_flush_fetch <= (state == ST_FLUSH);
      o_hard_fault <= accept && fetch_fault;
      o_size_fault <= accept && !fetch_fault && (size_bad || size_reserved || misaligned);
      if (bus_taken) begin
        o_bus_valid <= 1'b0;
      end
      if (issue) begin
        o_bus_valid <= 1'b1;
        o_bus_fetch <= i_req_fetch;
        o_bus_write <= i_req_write && !i_req_fetch;
        o_bus_addr <= i_req_addr;
        o_bus_wdata <= steered;
        o_bus_strobe <= strobe;
        o_bus_mem_type <= mem_type;
        o_bus_shareable <= shareable;
        o_bus_bufferable <= i_req_write && (mem_type == `MTYPE_DEVICE);
      end
    end
  end

endmodule

// ===== mem_attr_unit_sva.sv
// Checker of decode, fault, ordering and barrier behaviour
module mem_attr_unit_sva (
  // Core side
  input wire i_clk,
  input wire i_sys_rst,
  input wire i_req_valid,
  input wire i_req_fetch,
  input wire [1:0] i_req_size,
  input wire [31:0] i_req_addr,
  input wire o_req_ready,
  input wire i_barrier_valid,
  input wire o_barrier_done,
  input wire o_hard_fault,
  input wire o_size_fault,
  input wire o_flush_fetch,
  // Bus side
  input wire o_bus_valid,
  input wire [31:0] o_bus_addr,
  input wire [1:0] o_bus_mem_type,
  input wire o_bus_shareable,
  input wire o_bus_bufferable,
  input wire i_bus_ready,
  input wire i_bus_done
);
  wire acc = i_req_valid && o_req_ready;
  wire [31:0] a = i_req_addr;
  wire clean = i_req_size == 2'h2 && a[1:0] == 2'h0;
  wire [2:0] ba = o_bus_addr[31:29];
  wire so = o_bus_addr[31:20] == 12'he00;
  // Counts only handed-over transfers, so it never exceeds the unit's own count
  logic [7:0] cnt;
  always @(posedge i_clk)
    if (i_sys_rst) cnt <= 8'h0;
    else cnt <= cnt + 8'(o_bus_valid && i_bus_ready) - 8'(i_bus_done);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  AST_EXEC_NORMAL: assert property (
    acc && i_req_fetch && clean && (a[31:30] == 2'h0 || a[31:29] inside {3'h3, 3'h4})
    |=> o_bus_valid && o_bus_mem_type == 2'h0 && !o_hard_fault) else $error("executable fetch refused");
  AST_NO_EXEC: assert property (
    acc && i_req_fetch && clean && (a[31:29] == 3'h2 || a >= 32'ha0000000)
    |=> o_hard_fault && !o_bus_valid) else $error("no-execute fetch not faulted");
  AST_PPB_SIZE: assert property (
    acc && !i_req_fetch && a[31:20] == 12'he00 && i_req_size != 2'h2
    |=> o_size_fault && !o_bus_valid) else $error("narrow core peripheral access passed");
  AST_SO_ATTR: assert property (
    o_bus_valid && so |-> o_bus_mem_type == 2'h2 && o_bus_shareable && !o_bus_bufferable)
    else $error("core peripheral attributes wrong");
  AST_DEV_TYPE: assert property (
    o_bus_valid && !so && (ba inside {3'h2, 3'h5, 3'h6} || o_bus_addr >= 32'he0100000)
    |-> o_bus_mem_type == 2'h1) else $error("device region type wrong");
  AST_EXTDEV_SHARE: assert property (
    o_bus_valid && ba inside {3'h5, 3'h6} |-> o_bus_shareable == (ba == 3'h5))
    else $error("external device shareability wrong");
  AST_SO_WAIT: assert property (
    acc && !i_req_fetch && clean && a[31:20] == 12'he00 |-> cnt == 8'h0 || cnt == 8'h1 && i_bus_done)
    else $error("strongly ordered access passed outstanding ones");
  AST_BAR_DRAIN: assert property (
    o_barrier_done |-> cnt == 8'h0 && !o_bus_valid) else $error("barrier done with traffic open");
  AST_BAR_BOUND: assert property (
    $rose(i_barrier_valid) |-> ##[2:200] o_barrier_done) else $error("barrier never completed");
  AST_ISB_FLUSH: assert property (
    o_flush_fetch |-> o_barrier_done) else $error("flush outside barrier completion");
endmodule

bind mem_attr_unit mem_attr_unit_sva i_sva (.i_clk, .i_sys_rst, .i_req_valid, .i_req_fetch,
  .i_req_size, .i_req_addr, .o_req_ready, .i_barrier_valid, .o_barrier_done, .o_hard_fault,
  .o_size_fault, .o_flush_fetch, .o_bus_valid, .o_bus_addr, .o_bus_mem_type, .o_bus_shareable,
  .o_bus_bufferable, .i_bus_ready, .i_bus_done);

// ===== bus_fabric_model.sv
// Behavioural system bus fabric with prompt and slow answers
module bus_fabric_model (
  // Clock and reset
  input wire i_clk,
  input wire i_sys_rst,
  // Bus
  input wire i_valid,
  input wire i_slow,
  output logic o_ready,
  output logic o_done
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] stall;
  int pend;
  bit issue;
  always @(posedge i_clk) begin
    if (i_sys_rst || o_ready) begin
      o_ready <= 1'b0;
      stall <= i_slow ? 2'($urandom) : 2'h0;
    end else if (i_valid) begin
      if (stall == 2'h0) o_ready <= 1'b1;
      else stall <= stall - 2'h1;
    end
  end
  always @(posedge i_clk) begin
    issue = !i_sys_rst && pend > 0 && (!i_slow || $urandom_range(1) == 1);
    o_done <= issue;
    pend <= i_sys_rst ? 0 : pend + int'(i_valid && o_ready) - int'(issue);
  end
endmodule

// ===== default_memory_map_attributes_tb.sv
// Self-checking bench for the memory map attribute unit
module default_memory_map_attributes_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk = 0, i_sys_rst = 1, i_req_valid = 0, i_req_fetch = 0, i_req_write = 0;
  logic i_barrier_valid = 0, i_slow = 0, i_bus_ready, i_bus_done;
  logic [1:0] i_req_size = 0, i_barrier_kind = 0;
  logic [31:0] i_req_addr = 0, i_req_wdata = 0;
  logic o_req_ready, o_barrier_done, o_hard_fault, o_size_fault, o_flush_fetch, o_bus_valid;
  logic o_bus_fetch, o_bus_write, o_stall_execute;
  logic [31:0] o_bus_wdata, o_bus_addr;
  logic [3:0] o_bus_strobe;
  logic [1:0] o_bus_mem_type;
  int num_errors = 0, tests_run = 0, cycles = 0;
  logic [31:0] corner [14] = '{32'h0, 32'h1ffffffc, 32'h20000000, 32'h3ffffffc, 32'h40000000,
    32'h5ffffffc, 32'h60000000, 32'h9ffffffc, 32'ha0000000, 32'hdffffffc, 32'he0000000,
    32'he00ffffc, 32'he0100000, 32'hfffffffc};
  always #12.5 i_clk = ~i_clk;
  mem_attr_unit #(.OUTSTANDING_W(4), .BIG_ENDIAN(0)) i_dut (.i_clk, .i_sys_rst, .i_req_valid,
    .i_req_fetch, .i_req_write, .i_req_size, .i_req_addr, .i_req_wdata, .o_req_ready,
    .i_barrier_valid, .i_barrier_kind, .o_barrier_done, .o_hard_fault, .o_size_fault,
    .o_flush_fetch, .o_stall_execute, .o_bus_valid, .o_bus_fetch, .o_bus_write,
    .o_bus_addr, .o_bus_wdata, .o_bus_strobe, .o_bus_mem_type, .o_bus_shareable(),
    .o_bus_bufferable(), .i_bus_ready, .i_bus_done);
  bus_fabric_model i_fabric (.i_clk, .i_sys_rst, .i_valid(o_bus_valid), .i_slow,
    .o_ready(i_bus_ready), .o_done(i_bus_done));
  task automatic wrap_up;
    $display("tests_run=%0d num_errors=%0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // A hang ends the run as a failure
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      wrap_up();
    end
  end
  task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  // Fault bits, then bus type or 3 where no bus transfer may start
  function automatic [3:0] expect_resp(input bit f, input [1:0] sz, input [31:0] a);
    bit core_peripheral_space, dev;
    core_peripheral_space = a[31:20] == 12'he00;
    dev = a[31:29] inside {3'h2, 3'h5, 3'h6} || a >= 32'he0100000;
    if (sz == 2'h3 || sz == 2'h1 && a[0] || sz == 2'h2 && a[1:0] != 2'h0 || core_peripheral_space && !f && sz != 2'h2)
      return 4'h7;
    if (f && (core_peripheral_space || dev)) return 4'hb;
    return {2'h0, core_peripheral_space ? 2'h2 : {1'b0, dev}};
  endfunction
  task automatic req(input bit f, input bit w, input [1:0] sz, input [31:0] a);
    int n;
    logic [3:0] e, s;
    logic [31:0] m, d;
    e = expect_resp(f, sz, a);
    @(negedge i_clk);
    {i_req_valid, i_req_fetch, i_req_write, i_req_size, i_req_addr} = {1'b1, f, w, sz, a};
    i_req_wdata = $urandom;
    n = 0;
    #1;
    while (o_req_ready !== 1'b1 && n < 400) begin
      @(negedge i_clk);
      #1;
      n++;
    end
    @(negedge i_clk);
    i_req_valid = 1'b0;
    chk({o_hard_fault, o_size_fault, o_bus_valid ? o_bus_mem_type : 2'h3}, e);
    if (e[1:0] != 2'h3) chk({o_bus_fetch, o_bus_write, o_bus_addr}, {f, w && !f, a});
    if (w && !f && e[1:0] != 2'h3) begin
      s = sz == 2'h0 ? 4'h1 << a[1:0] : sz == 2'h1 ? 4'h3 << a[1:0] : 4'hf;
      m = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
      d = sz == 2'h0 ? {4{i_req_wdata[7:0]}} : sz == 2'h1 ? {2{i_req_wdata[15:0]}} : i_req_wdata;
      chk({o_bus_strobe, o_bus_wdata & m}, {s, d & m});
    end
  endtask
  task automatic bar(input [1:0] k);
    int n;
    @(negedge i_clk);
    i_barrier_valid = 1'b1;
    i_barrier_kind = k;
    n = 0;
    while (o_barrier_done !== 1'b1 && n < 400) begin
      if (n > 0) chk(o_stall_execute, k == 2'h2);
      @(negedge i_clk);
      n++;
    end
    i_barrier_valid = 1'b0;
    chk(o_flush_fetch, k == 2'h3);
    chk(n >= 2, 1);
  endtask
  initial begin
    int r;
    r = $urandom(33);
    repeat (3) @(negedge i_clk);
    i_sys_rst = 0;
    foreach (corner[k]) begin
      req(1, 0, 2'h2, corner[k]);
      req(0, 1, 2'h2, corner[k] | 32'($urandom_range(3)));
    end
    $display("region boundary test done");
    for (int s = 0; s < 4; s++) req(0, 1, 2'(s), 32'he000ed00);
    $display("core peripheral size test done");
    repeat (300) begin
      bit f;
      logic [31:0] a;
      i_slow = $urandom_range(1);
      f = $urandom_range(3) == 0;
      a = $urandom;
      if ($urandom_range(3) == 0) a[31:20] = 12'he00;
      if (f) a[1:0] = 2'h0;
      req(f, $urandom_range(1), f ? 2'h2 : 2'($urandom), a);
    end
    $display("random traffic test done");
    @(negedge i_clk);
    i_sys_rst = 1;
    @(negedge i_clk);
    chk({o_bus_valid, o_hard_fault, o_size_fault, o_barrier_done, o_flush_fetch, o_req_ready}, 6'h01);
    i_sys_rst = 0;
    $display("mid-run reset test done");
    i_slow = 1;
    for (int k = 1; k < 4; k++) begin
      req(0, 1, 2'h2, 32'h40000010);
      req(0, 1, 2'h0, 32'h20000003);
      bar(2'(k));
    end
    $display("barrier test done");
    wrap_up();
  end
endmodule
